// ### apdm_defs.svh
// constants for the always-on power domain manager
// Overview of operation
// - manager in always-on logic controls modes, domain switching, reset and wake-up
// - always-on logic stays powered and working in every system power mode
// - memory domain powered in states 0 to 3, off in deeper states
// - core logic domain powered only in states 0, 1 and 2
// - pads grouped into four switchable banks plus bank 4, named always-on but switchable like the others
// - each bank has its own power-off control, independent of the others
// - all banks start switched on after power-up
// - each bank low-voltage select resets to zero, standard 3.3V operation
// - pad regulators reset to normal mode; software may power them down
// - voltage selection may change at any time and must match the supply
// - pads of an unpowered bank are held tri-stated
// - retention scratch memory keeps contents in every power mode
// - 32-bit real-time counter in always-on logic runs through all modes
// - comparator supports differential and single-ended modes with reference select
// - comparator output raises interrupt, wake-up or both, each enabled separately
// - enabled brown-out resets core and peripherals, not manager or comparator
// - brown-out reset path disabled after reset
// - system mode pairs core and wireless states; full shut-down flagged in state 4 only with wireless off
// - two-bit mode field: 01 standby, 10 sleep, 11 shutoff at wait
`ifndef APDM_DEFS_SVH
`define APDM_DEFS_SVH
`define APDM_NUM_BANKS 4
`define APDM_BANKS_ON_RST 5'h1f
`define APDM_LV_SEL_RST 5'h00
`define APDM_REG_PDN_N_RST 5'h1f
`define APDM_AON_BANK 4
`define APDM_MODE_STANDBY 2'h1
`define APDM_MODE_SLEEP 2'h2
`define APDM_MODE_SHUTOFF 2'h3
`define APDM_WL_SHUTDOWN 2'h2
`define APDM_SCRATCH_AW 10
`define APDM_SCRATCH_WORDS 1024
`define APDM_ISO_LEAD_CYCLES 4'h2
`endif

// ### apdm_pkg.sv
// types for the always-on power domain manager
package apdm_pkg;
  typedef enum logic [2:0] {
    PM0, PM1, PM2, PM3, PM4, PM5
  } apdm_mcu_state_t;
  typedef enum logic [1:0] {
    ST_RUN, ST_ISOLATE, ST_LOW, ST_WAKE
  } apdm_seq_t;
endpackage

// ### apdm_mem_if.sv
// bus between the manager and its retention scratch memory
`timescale 1ns/1ps
interface apdm_mem_if;
  logic req;
  logic we;
  logic [9:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctrl (output req, output we, output addr, output wdata, input rdata);
  modport mem (input req, input we, input addr, input wdata, output rdata);
endinterface

// ### apdm_scratch_mem.sv
// retention scratch memory, always powered, registered read data
`timescale 1ns/1ps
`include "apdm_defs.svh"
module apdm_scratch_mem (
  input wire logic ref_clk,
  apdm_mem_if.mem bus
);
  logic [31:0] mem_ff [0:`APDM_SCRATCH_WORDS-1];
  logic [31:0] rdata_ff;

  // no reset on the array: contents must survive every mode
  always_ff @(posedge ref_clk) begin
    if (bus.req && bus.we) begin
      mem_ff[bus.addr] <= bus.wdata;
    end
    if (bus.req && !bus.we) begin
      rdata_ff <= mem_ff[bus.addr];
    end
  end
  assign bus.rdata = rdata_ff;
endmodule

// ### apdm_top.sv
// always-on power domain manager: mode tracking, domain gating, bank config
`timescale 1ns/1ps
`include "apdm_defs.svh"
module apdm_top (
  input wire logic ref_clk,
  input wire logic reset,
  // mode request and wait-for-interrupt from the core
  input wire logic [1:0] pwr_mode_req,
  input wire logic core_wfi,
  input wire logic core_sleepdeep,
  input wire logic wake_event,
  input wire logic [1:0] wireless_state,
  // bank configuration writes
  input wire logic cfg_we,
  input wire logic [4:0] cfg_bank_power_on,
  input wire logic [4:0] cfg_low_voltage_select,
  input wire logic [4:0] cfg_pad_regulator_powerdown_n,
  input wire logic [4:0] pad_out_en_req,
  // comparator
  input wire logic cmp_we,
  input wire logic cmp_single_ended,
  input wire logic [1:0] cmp_ref_sel,
  input wire logic cmp_irq_en,
  input wire logic cmp_wake_en,
  input wire logic cmp_raw,
  // brown-out
  input wire logic brn_we,
  input wire logic brn_reset_enable,
  input wire logic brn_event,
  // scratch memory port
  input wire logic scr_req,
  input wire logic scr_we,
  input wire logic [9:0] scr_addr,
  input wire logic [31:0] scr_wdata,
  output logic [31:0] scr_rdata,
  // outputs
  output logic mem_pwr_en,
  output logic mem_iso,
  output logic core_pwr_en,
  output logic core_iso,
  output logic [4:0] bank_power_on,
  output logic [4:0] low_voltage_select,
  output logic [4:0] pad_regulator_powerdown_n,
  output logic [4:0] pad_out_en,
  output logic [2:0] mcu_state,
  output logic [1:0] wl_state,
  output logic full_shutdown_system_mode,
  output logic cmp_mode_single,
  output logic [1:0] cmp_ref,
  output logic cmp_irq,
  output logic cmp_wake,
  output logic periph_reset,
  output logic [31:0] rtc_count
);
  apdm_mem_if mbus ();
  apdm_scratch_mem u_mem (
    .ref_clk(ref_clk),
    .bus(mbus)
  );
  assign mbus.req = scr_req;
  assign mbus.we = scr_we;
  assign mbus.addr = scr_addr;
  assign mbus.wdata = scr_wdata;
  assign scr_rdata = mbus.rdata;

  // ------------------------------------------------------------
  // mode sequencer
  // ------------------------------------------------------------
  apdm_pkg::apdm_mcu_state_t st_ff, nxt_st, tgt_ff, nxt_tgt;
  apdm_pkg::apdm_seq_t seq_ff, nxt_seq;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [1:0] wl_ff;
  logic cmp_wake_en_ff;

  // decode a mode request into the low-power state it enters
  function automatic apdm_pkg::apdm_mcu_state_t mode_target(input logic [1:0] m);
    unique case (m)
      `APDM_MODE_STANDBY: mode_target = apdm_pkg::PM2;
      `APDM_MODE_SLEEP: mode_target = apdm_pkg::PM3;
      `APDM_MODE_SHUTOFF: mode_target = apdm_pkg::PM4;
      default: mode_target = apdm_pkg::PM1;
    endcase
  endfunction

  // domain power per state
  function automatic logic mem_on(input apdm_pkg::apdm_mcu_state_t s);
    mem_on = (s == apdm_pkg::PM0) || (s == apdm_pkg::PM1) ||
             (s == apdm_pkg::PM2) || (s == apdm_pkg::PM3);
  endfunction
  function automatic logic core_on(input apdm_pkg::apdm_mcu_state_t s);
    core_on = (s == apdm_pkg::PM0) || (s == apdm_pkg::PM1) ||
              (s == apdm_pkg::PM2);
  endfunction

  wire logic enter_wfi = core_wfi && (st_ff == apdm_pkg::PM0);
  // wfi without deep sleep is plain idle; deep sleep takes the mode field
  wire apdm_pkg::apdm_mcu_state_t req_tgt =
    core_sleepdeep ? mode_target(pwr_mode_req) : apdm_pkg::PM1;
  // full shut-down flagged only with the wireless side already off; PM4 is entered either way
  wire logic shut_ok = (wl_ff == `APDM_WL_SHUTDOWN);
  wire apdm_pkg::apdm_mcu_state_t adj_tgt =
    (req_tgt == apdm_pkg::PM4 && shut_ok && !wireless_state[0]) ? apdm_pkg::PM4 : req_tgt;

  // isolation leads power removal by a fixed count in ST_ISOLATE
  always_comb begin
    nxt_st = st_ff;
    nxt_tgt = tgt_ff;
    nxt_seq = seq_ff;
    nxt_cnt = cnt_ff;
    unique case (seq_ff)
      apdm_pkg::ST_RUN: begin
        if (enter_wfi) begin
          nxt_tgt = adj_tgt;
          nxt_cnt = 4'h0;
          nxt_seq = apdm_pkg::ST_ISOLATE;
        end
      end
      apdm_pkg::ST_ISOLATE: begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == `APDM_ISO_LEAD_CYCLES) begin
          nxt_st = tgt_ff;
          nxt_seq = apdm_pkg::ST_LOW;
        end
      end
      apdm_pkg::ST_LOW: begin
        if (wake_event || (cmp_wake_en_ff && cmp_raw)) begin
          nxt_st = apdm_pkg::PM0; // power returns first, isolation lifts next
          nxt_cnt = 4'h0;
          nxt_seq = apdm_pkg::ST_WAKE;
        end
      end
      apdm_pkg::ST_WAKE: begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == `APDM_ISO_LEAD_CYCLES) begin
          nxt_seq = apdm_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= apdm_pkg::PM0;
      tgt_ff <= apdm_pkg::PM0;
      seq_ff <= apdm_pkg::ST_RUN;
      cnt_ff <= 4'h0;
      wl_ff <= 2'h0;
    end else begin
      st_ff <= nxt_st;
      tgt_ff <= nxt_tgt;
      seq_ff <= nxt_seq;
      cnt_ff <= nxt_cnt;
      wl_ff <= wireless_state;
    end
  end

  // ------------------------------------------------------------
  // domain enables and isolation
  // ------------------------------------------------------------
  // isolate from the start of a descent until the wake settle ends
  wire logic iso_win = (seq_ff != apdm_pkg::ST_RUN);
  wire logic nxt_mem_iso = iso_win && !mem_on(tgt_ff);
  wire logic nxt_core_iso = iso_win && !core_on(tgt_ff);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_pwr_en <= 1'b1;
      core_pwr_en <= 1'b1;
      mem_iso <= 1'b0;
      core_iso <= 1'b0;
      mcu_state <= 3'h0;
      wl_state <= 2'h0;
      full_shutdown_system_mode <= 1'b0;
    end else begin
      mem_pwr_en <= mem_on(nxt_st);
      core_pwr_en <= core_on(nxt_st);
      mem_iso <= nxt_mem_iso;
      core_iso <= nxt_core_iso;
      mcu_state <= nxt_st;
      wl_state <= wl_ff;
      full_shutdown_system_mode <= (nxt_st == apdm_pkg::PM4) && shut_ok;
    end
  end

  // ------------------------------------------------------------
  // io bank configuration, always-on registers
  // ------------------------------------------------------------
  // bit 4 is the always-on bank, but cfg_we loads and can switch it off like bits 0..3
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bank_power_on <= `APDM_BANKS_ON_RST;
      low_voltage_select <= `APDM_LV_SEL_RST;
      pad_regulator_powerdown_n <= `APDM_REG_PDN_N_RST;
    end else if (cfg_we) begin
      bank_power_on <= cfg_bank_power_on;
      low_voltage_select <= cfg_low_voltage_select;
      pad_regulator_powerdown_n <= cfg_pad_regulator_powerdown_n;
    end
  end

  // gate with the incoming bank power so a switch-off never lets a pad drive for a cycle
  wire logic [4:0] nxt_bank_on = cfg_we ? cfg_bank_power_on : bank_power_on;

  // unpowered bank pads stay tri-stated
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pad_out_en <= 5'h00;
    end else begin
      pad_out_en <= pad_out_en_req & nxt_bank_on;
    end
  end

  // ------------------------------------------------------------
  // comparator control
  // ------------------------------------------------------------
  logic cmp_irq_en_ff;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cmp_mode_single <= 1'b0;
      cmp_ref <= 2'h0;
      cmp_irq_en_ff <= 1'b0;
      cmp_wake_en_ff <= 1'b0;
    end else if (cmp_we) begin
      cmp_mode_single <= cmp_single_ended;
      cmp_ref <= cmp_ref_sel;
      cmp_irq_en_ff <= cmp_irq_en;
      cmp_wake_en_ff <= cmp_wake_en;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cmp_irq <= 1'b0;
      cmp_wake <= 1'b0;
    end else begin
      cmp_irq <= cmp_raw && cmp_irq_en_ff;
      cmp_wake <= cmp_raw && cmp_wake_en_ff;
    end
  end

  // ------------------------------------------------------------
  // brown-out reset path and real-time counter
  // ------------------------------------------------------------
  // the brown-out pulse only touches periph_reset, never this block
  logic brn_en_ff;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      brn_en_ff <= 1'b0;
      periph_reset <= 1'b0;
      rtc_count <= 32'h0000_0000;
    end else begin
      if (brn_we) begin
        brn_en_ff <= brn_reset_enable;
      end
      periph_reset <= brn_event && brn_en_ff;
      rtc_count <= rtc_count + 32'h0000_0001;
    end
  end
endmodule

// ### apdm_top_sva.sv
// checker on the top ports of the always-on power domain manager
`timescale 1ns/1ps
module apdm_top_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cfg_we,
  input wire logic [4:0] cfg_bank_power_on,
  input wire logic [4:0] cfg_low_voltage_select,
  input wire logic cmp_raw,
  input wire logic brn_event,
  input wire logic [4:0] bank_power_on,
  input wire logic [4:0] low_voltage_select,
  input wire logic [4:0] pad_out_en,
  input wire logic mem_pwr_en,
  input wire logic core_pwr_en,
  input wire logic core_iso,
  input wire logic [2:0] mcu_state,
  input wire logic [1:0] wl_state,
  input wire logic full_shutdown_system_mode,
  input wire logic cmp_irq,
  input wire logic cmp_wake,
  input wire logic periph_reset,
  input wire logic [31:0] rtc_count
);
  // ----
  // one clock domain, reset disables all
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // clamps must stand two cycles before the core loses power
  sequence s_iso_lead;
    (core_iso && core_pwr_en) ##1 (core_iso && core_pwr_en);
  endsequence
  a_iso_leads: assert property ($rose(core_iso) |-> s_iso_lead)
    else $error("isolation lead too short");
  a_core_dom: assert property (core_pwr_en == (mcu_state < 3'h3))
    else $error("core domain power wrong for state");
  a_mem_dom: assert property (mem_pwr_en == (mcu_state < 3'h4))
    else $error("memory domain power wrong for state");
  a_bank_load: assert property (cfg_we |=> bank_power_on == $past(cfg_bank_power_on)
    && low_voltage_select == $past(cfg_low_voltage_select))
    else $error("bank config not loaded");
  a_pad_tristate: assert property ((pad_out_en & ~bank_power_on) == 5'h00)
    else $error("pad driven on unpowered bank");
  a_cmp_cause: assert property ((cmp_irq || cmp_wake) |-> $past(cmp_raw))
    else $error("comparator event without cause");
  a_brn_cause: assert property (periph_reset |-> $past(brn_event))
    else $error("peripheral reset without brown-out");
  a_rtc_step: assert property (!$past(reset) |-> rtc_count == $past(rtc_count) + 32'h1)
    else $error("real-time counter stalled");
  a_shut_pair: assert property (full_shutdown_system_mode |-> wl_state == 2'h2)
    else $error("full shutdown with wireless on");
endmodule
bind apdm_top apdm_top_chk apdm_top_chk_i (.ref_clk(ref_clk), .reset(reset), .cfg_we(cfg_we),
  .cfg_bank_power_on(cfg_bank_power_on), .cfg_low_voltage_select(cfg_low_voltage_select),
  .cmp_raw(cmp_raw), .brn_event(brn_event), .bank_power_on(bank_power_on),
  .low_voltage_select(low_voltage_select), .pad_out_en(pad_out_en), .mem_pwr_en(mem_pwr_en),
  .core_pwr_en(core_pwr_en), .core_iso(core_iso), .mcu_state(mcu_state), .wl_state(wl_state),
  .full_shutdown_system_mode(full_shutdown_system_mode), .cmp_irq(cmp_irq),
  .cmp_wake(cmp_wake), .periph_reset(periph_reset), .rtc_count(rtc_count));

// ### apdm_core_model.sv
// core-side model: wait-for-interrupt entry and wake-up
`timescale 1ns/1ps
module apdm_core_model (
  input wire logic ref_clk,
  output logic core_wfi,
  output logic core_sleepdeep,
  output logic [1:0] pwr_mode_req,
  output logic wake_event
);
  // ----
  // idle levels at start
  // ----
  initial begin
    {core_wfi, core_sleepdeep, pwr_mode_req, wake_event} = 5'h00;
  end
  // mode stays as a level; caller has banks 0..3 off already
  task enter(input logic deep, input logic [1:0] mode);
    @(negedge ref_clk);
    core_sleepdeep = deep;
    pwr_mode_req = mode;
    core_wfi = 1'b1;
    @(negedge ref_clk);
    core_wfi = 1'b0;
  endtask
  // one-cycle wake pulse
  task wake();
    @(negedge ref_clk);
    wake_event = 1'b1;
    @(negedge ref_clk);
    wake_event = 1'b0;
  endtask
endmodule

// ### apdm_top_tb_top.sv
// self-checking bench for the power domain manager
`timescale 1ns/1ps
`include "apdm_defs.svh"
module apdm_top_tb_top;
  logic ref_clk, reset, cfg_we, cmp_we, cmp_single_ended, cmp_irq_en, cmp_wake_en, cmp_raw;
  logic brn_we, brn_reset_enable, brn_event, scr_req, scr_we, core_wfi, core_sleepdeep;
  logic wake_event, mem_pwr_en, mem_iso, core_pwr_en, core_iso, full_shutdown_system_mode;
  logic cmp_mode_single, cmp_irq, cmp_wake, periph_reset;
  logic [1:0] pwr_mode_req, wireless_state, cmp_ref_sel, wl_state, cmp_ref;
  logic [2:0] mcu_state;
  logic [4:0] cfg_bank_power_on, cfg_low_voltage_select, cfg_pad_regulator_powerdown_n, m, k;
  logic [4:0] pad_out_en_req, bank_power_on, low_voltage_select, pad_regulator_powerdown_n;
  logic [4:0] pad_out_en;
  logic [9:0] scr_addr;
  logic [31:0] scr_wdata, scr_rdata, rtc_count, t0;
  int bad_count = 0;
  int checks = 0;
  // mode table: deep flag, mode field, wireless state, expected state
  logic dp_t [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [1:0] md_t [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [1:0] wl_t [5] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
  logic [2:0] st_t [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
  apdm_top apdm_top_i (.ref_clk(ref_clk), .reset(reset), .pwr_mode_req(pwr_mode_req),
    .core_wfi(core_wfi), .core_sleepdeep(core_sleepdeep), .wake_event(wake_event),
    .wireless_state(wireless_state), .cfg_we(cfg_we), .cfg_bank_power_on(cfg_bank_power_on),
    .cfg_low_voltage_select(cfg_low_voltage_select), .pad_out_en_req(pad_out_en_req),
    .cfg_pad_regulator_powerdown_n(cfg_pad_regulator_powerdown_n), .cmp_we(cmp_we),
    .cmp_single_ended(cmp_single_ended), .cmp_ref_sel(cmp_ref_sel), .cmp_irq_en(cmp_irq_en),
    .cmp_wake_en(cmp_wake_en), .cmp_raw(cmp_raw), .brn_we(brn_we), .brn_event(brn_event),
    .brn_reset_enable(brn_reset_enable), .scr_req(scr_req), .scr_we(scr_we),
    .scr_addr(scr_addr), .scr_wdata(scr_wdata), .scr_rdata(scr_rdata),
    .mem_pwr_en(mem_pwr_en), .mem_iso(mem_iso), .core_pwr_en(core_pwr_en),
    .core_iso(core_iso), .bank_power_on(bank_power_on), .pad_out_en(pad_out_en),
    .low_voltage_select(low_voltage_select), .mcu_state(mcu_state), .wl_state(wl_state),
    .pad_regulator_powerdown_n(pad_regulator_powerdown_n), .cmp_ref(cmp_ref),
    .full_shutdown_system_mode(full_shutdown_system_mode), .cmp_mode_single(cmp_mode_single),
    .cmp_irq(cmp_irq), .cmp_wake(cmp_wake), .periph_reset(periph_reset),
    .rtc_count(rtc_count));
  apdm_core_model apdm_core_model_i (.ref_clk(ref_clk), .core_wfi(core_wfi),
    .core_sleepdeep(core_sleepdeep), .pwr_mode_req(pwr_mode_req), .wake_event(wake_event));
  // ----
  // clock and helpers
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task stop_test();
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait; back in run means state 0 with clamps released
  task wait_state(input logic [2:0] s);
    int n;
    n = 0;
    while (!(mcu_state === s && (s != 3'h0 || core_iso === 1'b0))) begin
      @(negedge ref_clk);
      n++;
      if (n > 20) begin
        bad_count++;
        stop_test();
      end
    end
    @(negedge ref_clk);
    // the wake settle still refuses wfi and no port shows its end, so sit it out
    if (s == 3'h0) begin
      repeat (`APDM_ISO_LEAD_CYCLES + 4'h2) @(negedge ref_clk);
    end
  endtask
  // regulators follow bank power to save the most
  task cfg(input logic [4:0] on, input logic [4:0] lv);
    @(negedge ref_clk);
    {cfg_we, cfg_bank_power_on, cfg_low_voltage_select} = {1'b1, on, lv};
    cfg_pad_regulator_powerdown_n = on;
    @(negedge ref_clk);
    cfg_we = 1'b0;
  endtask
  task cmpcfg(input logic se, input logic [1:0] rs, input logic ie, input logic wk);
    @(negedge ref_clk);
    {cmp_we, cmp_single_ended, cmp_ref_sel, cmp_irq_en, cmp_wake_en} = {1'b1, se, rs, ie, wk};
    @(negedge ref_clk);
    cmp_we = 1'b0;
    @(negedge ref_clk);
  endtask
  task scr(input logic we, input logic [9:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    {scr_req, scr_we, scr_addr, scr_wdata} = {1'b1, we, a, d};
    @(negedge ref_clk);
    scr_req = 1'b0;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    reset = 1'b1;
    {cfg_we, cmp_we, cmp_single_ended, cmp_irq_en, cmp_wake_en, cmp_raw, cmp_ref_sel} = 7'h00;
    {brn_we, brn_reset_enable, brn_event, scr_req, scr_we, scr_addr, scr_wdata} = '0;
    {cfg_bank_power_on, cfg_low_voltage_select, cfg_pad_regulator_powerdown_n} = 15'h7c1f;
    {pad_out_en_req, wireless_state} = 7'h7d;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    chk(bank_power_on, 5'h1f);
    chk(low_voltage_select, 5'h00);
    chk(pad_regulator_powerdown_n, 5'h1f);
    brn_event = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(periph_reset, 1'b0);
    // detector threshold lives outside; the enable comes last
    {brn_we, brn_reset_enable} = 2'h3;
    @(negedge ref_clk);
    brn_we = 1'b0;
    @(negedge ref_clk);
    chk(periph_reset, 1'b1);
    brn_event = 1'b0;
    for (int i = 0; i < 5; i++) begin
      m = 5'h01 << i;
      k = ~m;
      cfg(k, m);
      chk({bank_power_on, low_voltage_select}, {k, m});
      @(negedge ref_clk);
      chk({pad_out_en, pad_regulator_powerdown_n}, {k, k});
    end
    cmp_raw = 1'b1;
    cmpcfg(1'b1, 2'h2, 1'b1, 1'b0);
    chk({cmp_mode_single, cmp_ref, cmp_irq, cmp_wake}, 5'h1a);
    cmpcfg(1'b0, 2'h1, 1'b0, 1'b1);
    chk({cmp_mode_single, cmp_ref, cmp_irq, cmp_wake}, 5'h05);
    cmp_raw = 1'b0;
    cmpcfg(1'b0, 2'h0, 1'b0, 1'b0);
    scr(1'b1, 10'h3ff, 32'ha5c30f1e);
    cfg(5'h10, 5'h00);
    for (int i = 0; i < 5; i++) begin
      wireless_state = wl_t[i];
      apdm_core_model_i.enter(dp_t[i], md_t[i]);
      wait_state(st_t[i]);
      chk({core_pwr_en, mem_pwr_en}, {st_t[i] < 3'h3, st_t[i] < 3'h4});
      chk({core_iso, mem_iso}, {st_t[i] > 3'h2, st_t[i] > 3'h3});
      chk(full_shutdown_system_mode, st_t[i] == 3'h4 && wl_t[i] == 2'h2);
      apdm_core_model_i.wake();
      wait_state(3'h0);
    end
    scr(1'b0, 10'h3ff, 32'h00000000);
    chk(scr_rdata, 32'ha5c30f1e);
    cfg(5'h1f, 5'h00);
    t0 = rtc_count;
    repeat (10) @(negedge ref_clk);
    chk(rtc_count - t0, 32'h0000000a);
    stop_test();
  end
endmodule
